// *** dv/spp_sva.sv ***
// concurrent checks on the byte-wide port between master and slave
`timescale 1ns/1ps
`default_nettype none
module spp_sva (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // port signals
    input wire logic       port_select_n,
    input wire logic       port_read_strobe_n,
    input wire logic       port_write_strobe_n,
    input wire logic [1:0] register_select,
    input wire logic [7:0] bus_from_master,
    input wire logic       master_drive,
    input wire logic       slave_drive,
    input wire logic       attention_out_n
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // wire properties
    // ------------------------------------------------------------
    property p_one_driver;
        !(slave_drive && master_drive) && (port_read_strobe_n || port_write_strobe_n);
    endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("bus contention or overlapping strobes");
    property p_slave_drv;
        $rose(slave_drive) |-> !port_read_strobe_n && !port_select_n;
    endproperty
    a_slave_drv: assert property (p_slave_drv)
        else $error("slave drove bus outside a read");
    property p_drv_write;
        slave_drive |-> port_write_strobe_n;
    endproperty
    a_drv_write: assert property (p_drv_write)
        else $error("slave drove bus during a write");
    // width kept well past the sync path so each strobe is seen once
    property p_wr_width;
        $fell(port_write_strobe_n) |-> !port_write_strobe_n [*6];
    endproperty
    a_wr_width: assert property (p_wr_width)
        else $error("write strobe too short");
    property p_rd_width;
        $fell(port_read_strobe_n) |-> !port_read_strobe_n [*6];
    endproperty
    a_rd_width: assert property (p_rd_width)
        else $error("read strobe too short");
    property p_wr_hold;
        !port_write_strobe_n |-> !port_select_n && master_drive
            && $stable(register_select) && $stable(bus_from_master);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("select or data moved during write");
    property p_rd_hold;
        !port_read_strobe_n |-> !port_select_n && !master_drive && $stable(register_select);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("select moved during read");
    property p_attn_rd;
        $fell(port_read_strobe_n) && !attention_out_n |-> ##[1:8] attention_out_n;
    endproperty
    a_attn_rd: assert property (p_attn_rd)
        else $error("attention kept after master read");
    property p_attn_wr;
        $rose(port_write_strobe_n) && !attention_out_n |-> ##[1:8] attention_out_n;
    endproperty
    a_attn_wr: assert property (p_attn_wr)
        else $error("attention kept after master write");
    c_write: cover property ($fell(port_write_strobe_n));
    c_read: cover property ($rose(slave_drive));
    c_attn: cover property ($fell(attention_out_n));
endmodule : spp_sva
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench joining slave and master ends across the port
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  s_addr = 4'h0;
    logic [7:0]  s_wdata = 8'h00;
    logic        s_wr = 1'b0;
    logic        s_rd = 1'b0;
    logic [3:0]  m_addr = 4'h0;
    logic [11:0] m_wdata = 12'h000;
    logic        m_wr = 1'b0;
    logic        m_rd = 1'b0;
    logic [7:0]  s_rdata, m_rdata, x, y, z;
    logic [7:0]  b [3], c [3];
    logic [1:0]  port_prio;
    logic        port_irq, s_irq, m_irq, s_seen = 1'b0, m_seen = 1'b0;
    logic [7:0]  q_s [$], q_m [$];
    int          bad_count = 0, compares = 0;
    spp_if u_spp_if ();
    spp_slave u_spp_slave (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(s_addr), .wdata_i(s_wdata),
        .wr_i(s_wr), .rd_i(s_rd), .rdata_o(s_rdata), .port_irq_o(port_irq),
        .port_irq_prio_o(port_prio), .irq_o(s_irq), .link(u_spp_if));
    spp_master u_spp_master (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(m_addr),
        .wdata_i(m_wdata), .wr_i(m_wr), .rd_i(m_rd), .rdata_o(m_rdata), .irq_o(m_irq),
        .link(u_spp_if));
    spp_sva u_spp_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .port_select_n(u_spp_if.port_select_n), .port_read_strobe_n(u_spp_if.port_read_strobe_n),
        .port_write_strobe_n(u_spp_if.port_write_strobe_n),
        .register_select(u_spp_if.register_select), .bus_from_master(u_spp_if.bus_from_master),
        .master_drive(u_spp_if.master_drive), .slave_drive(u_spp_if.slave_drive),
        .attention_out_n(u_spp_if.attention_out_n));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check_byte
    task automatic check_bit(input string n, input logic e, input logic s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", n, e, s);
        end
    endtask : check_bit
    task automatic complete_run;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    // one strobe cycle, then an idle edge so no strobe is set twice in one step
    task automatic bus(input bit m, input bit w, input logic [3:0] a, input logic [11:0] d);
        if (m) begin
            m_addr <= a;
            m_wdata <= d;
            m_wr <= w;
            m_rd <= !w;
        end else begin
            s_addr <= a;
            s_wdata <= d[7:0];
            s_wr <= w;
            s_rd <= !w;
        end
        @(posedge clk_i);
        {m_wr, m_rd, s_wr, s_rd} <= 4'h0;
        @(posedge clk_i);
    endtask : bus
    task automatic rd(input bit m, input logic [3:0] a, input logic [7:0] e);
        if (m) q_m.push_back(e);
        else q_s.push_back(e);
        bus(m, 1'b0, a, 12'h000);
    endtask : rd
    task automatic mc(input logic [1:0] sel, input bit r, input logic [7:0] d);
        int n;
        bus(1'b1, 1'b1, spp_pkg::MA_CMD, {sel, r, !r, d});
        n = 0;
        while (m_irq !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        check_bit("master done irq", 1'b1, m_irq);
        bus(1'b1, 1'b1, spp_pkg::MA_IRQ_ST, 12'h002);
        repeat (2) @(posedge clk_i);
    endtask : mc
    always @(posedge clk_i) begin
        if (s_seen) check_byte("slave rdata", q_s.pop_front(), s_rdata);
        if (m_seen) check_byte("master rdata", q_m.pop_front(), m_rdata);
        s_seen <= s_rd;
        m_seen <= m_rd;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        complete_run();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(27586));
        for (int i = 0; i < 3; i++) begin
            b[i] = 8'($urandom);
            c[i] = 8'($urandom);
        end
        {x, y, z} = 24'($urandom);
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b0, 1'b1, spp_pkg::PA_CTRL, 12'h009);
        bus(1'b0, 1'b1, spp_pkg::PA_IRQ_MK, 12'h007);
        bus(1'b1, 1'b1, spp_pkg::MA_IRQ_MK, 12'h002);
        // inbound bytes, data zero last
        for (int i = 2; i >= 0; i--) mc(2'(i), 1'b0, b[i]);
        check_bit("port irq", 1'b1, port_irq);
        check_bit("slave irq", 1'b1, s_irq);
        rd(1'b0, spp_pkg::PA_STATUS, 8'hf0);
        rd(1'b0, spp_pkg::PA_STATUS, 8'h70);
        check_bit("port irq", 1'b0, port_irq);
        for (int i = 0; i < 3; i++) rd(1'b0, 4'(i), b[i]);
        rd(1'b0, spp_pkg::PA_STATUS, 8'h00);
        rd(1'b0, 4'hf, 8'h00);
        bus(1'b0, 1'b1, spp_pkg::PA_IRQ_ST, 12'h007);
        repeat (2) @(posedge clk_i);
        check_bit("slave irq", 1'b0, s_irq);
        // outbound bytes, polled back by the master
        for (int i = 2; i >= 0; i--) bus(1'b0, 1'b1, 4'(i), {4'h0, c[i]});
        repeat (2) @(posedge clk_i);
        check_bit("attention", 1'b0, u_spp_if.attention_out_n);
        rd(1'b1, spp_pkg::MA_STAT, 8'h02);
        rd(1'b1, spp_pkg::MA_IRQ_ST, 8'h01);
        mc(spp_pkg::SEL_DATA1, 1'b1, 8'h00);
        check_bit("attention", 1'b1, u_spp_if.attention_out_n);
        rd(1'b1, spp_pkg::MA_RDATA, c[1]);
        rd(1'b0, spp_pkg::PA_IRQ_ST, 8'h06);
        mc(spp_pkg::SEL_DATA2, 1'b1, 8'h00);
        rd(1'b1, spp_pkg::MA_RDATA, c[2]);
        mc(spp_pkg::SEL_DATA0, 1'b1, 8'h00);
        rd(1'b1, spp_pkg::MA_RDATA, c[0]);
        mc(spp_pkg::SEL_STATUS, 1'b1, 8'h00);
        rd(1'b1, spp_pkg::MA_RDATA, 8'h00);
        // dummy status writes leave data untouched
        bus(1'b0, 1'b1, spp_pkg::PA_DATA0, {4'h0, x});
        mc(spp_pkg::SEL_STATUS, 1'b0, 8'h00);
        check_bit("attention", 1'b1, u_spp_if.attention_out_n);
        mc(spp_pkg::SEL_DATA0, 1'b1, 8'h00);
        rd(1'b1, spp_pkg::MA_RDATA, x);
        mc(spp_pkg::SEL_DATA0, 1'b0, y);
        mc(spp_pkg::SEL_STATUS, 1'b0, 8'h00);
        check_bit("port irq", 1'b0, port_irq);
        rd(1'b0, spp_pkg::PA_DATA0, y);
        // priority gating and interrupt mask
        bus(1'b0, 1'b1, spp_pkg::PA_IRQ_ST, 12'h007);
        bus(1'b0, 1'b1, spp_pkg::PA_IRQ_MK, 12'h000);
        bus(1'b0, 1'b1, spp_pkg::PA_CTRL, 12'h008);
        mc(spp_pkg::SEL_DATA0, 1'b0, z);
        check_bit("port irq", 1'b0, port_irq);
        bus(1'b0, 1'b1, spp_pkg::PA_CTRL, 12'h00a);
        @(posedge clk_i);
        check_bit("port irq", 1'b1, port_irq);
        check_byte("priority", 8'h02, {6'h00, port_prio});
        mc(spp_pkg::SEL_DATA0, 1'b0, x);
        check_bit("slave irq", 1'b0, s_irq);
        bus(1'b0, 1'b1, spp_pkg::PA_IRQ_MK, 12'h001);
        repeat (2) @(posedge clk_i);
        check_bit("slave irq", 1'b1, s_irq);
        bus(1'b0, 1'b1, spp_pkg::PA_IRQ_ST, 12'h001);
        repeat (2) @(posedge clk_i);
        check_bit("slave irq", 1'b0, s_irq);
        rd(1'b0, spp_pkg::PA_DATA0, x);
        // port disabled: strobes ignored, attention held off
        bus(1'b0, 1'b1, spp_pkg::PA_CTRL, 12'h000);
        bus(1'b0, 1'b1, spp_pkg::PA_DATA0, {4'h0, y});
        repeat (2) @(posedge clk_i);
        check_bit("attention", 1'b1, u_spp_if.attention_out_n);
        mc(spp_pkg::SEL_DATA1, 1'b0, z);
        rd(1'b0, spp_pkg::PA_DATA1, b[1]);
        repeat (4) @(posedge clk_i);
        complete_run();
    end
endmodule : tb
`default_nettype wire

// *** rtl/spp_if.sv ***
// byte-wide port wiring between master and slave
`timescale 1ns/1ps
`default_nettype none
interface spp_if;
    logic       port_select_n;
    logic       port_read_strobe_n;
    logic       port_write_strobe_n;
    logic [1:0] register_select;
    logic [7:0] bus_from_master;
    logic       master_drive;
    logic [7:0] bus_from_slave;
    logic       slave_drive;
    logic       attention_out_n;
    logic [7:0] port_byte_bus;
    // resolved bus level seen by both ends
    assign port_byte_bus = slave_drive ? bus_from_slave :
                           (master_drive ? bus_from_master : 8'hff);
    modport slave (
        input  port_select_n, port_read_strobe_n, port_write_strobe_n,
        input  register_select, port_byte_bus,
        output bus_from_slave, slave_drive, attention_out_n
    );
    modport master (
        output port_select_n, port_read_strobe_n, port_write_strobe_n,
        output register_select, bus_from_master, master_drive,
        input  port_byte_bus, attention_out_n
    );
endinterface : spp_if
`default_nettype wire

// *** rtl/spp_master.sv ***
// master end: runs one strobe cycle per software command
`timescale 1ns/1ps
`default_nettype none
module spp_master (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // command port
    input  wire logic [3:0] addr_i,
    input  wire logic [11:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            irq_o,
    // link to the slave
    spp_if.master           link
);
    typedef enum logic [1:0] {M_IDLE, M_SETUP, M_STROBE, M_GAP} spp_mst_state_t;
    spp_mst_state_t state;
    logic [3:0] cnt;
    logic       is_rd;
    logic [1:0] sel;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [1:0] attn_q;
    logic [7:0] ist;
    logic [7:0] imask;
    wire busy  = state != M_IDLE;
    wire go    = wr_i && addr_i == spp_pkg::MA_CMD && !busy &&
                 (wdata_i[spp_pkg::CMD_RD] || wdata_i[spp_pkg::CMD_WR]);
    wire done  = state == M_GAP && cnt == 4'h0;
    wire attn_fall = attn_q[1] && !attn_q[0]; // [R5]
    wire [7:0] ev = {6'h00, done, attn_fall};
    // ------------------------------------------------------------
    // bus cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= M_IDLE;
            cnt   <= 4'h0;
            is_rd <= 1'b0;
            sel   <= 2'h0;
            wbyte <= 8'h00;
            rbyte <= 8'h00;
        end else begin
            case (state)
                M_IDLE: if (go) begin
                    is_rd <= wdata_i[spp_pkg::CMD_RD];
                    sel   <= wdata_i[spp_pkg::CMD_SEL +: 2];
                    wbyte <= wdata_i[7:0];
                    cnt   <= 4'(spp_pkg::SETUP_CYC);
                    state <= M_SETUP;
                end
                M_SETUP: if (cnt == 4'h0) begin
                    cnt   <= 4'(spp_pkg::HOLD_CYC);
                    state <= M_STROBE;
                end else cnt <= cnt - 4'h1;
                M_STROBE: if (cnt == 4'h0) begin
                    if (is_rd) rbyte <= link.port_byte_bus; // [R1]
                    cnt   <= 4'(spp_pkg::GAP_CYC + 2);
                    state <= M_GAP;
                end else cnt <= cnt - 4'h1;
                M_GAP: if (cnt == 4'h0) state <= M_IDLE;
                       else cnt <= cnt - 4'h1;
                default: state <= M_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // link pins and command registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link.port_select_n       <= 1'b1;
            link.port_read_strobe_n  <= 1'b1;
            link.port_write_strobe_n <= 1'b1;
            link.register_select     <= 2'h0;
            link.bus_from_master     <= 8'h00;
            link.master_drive        <= 1'b0;
            // idle level of the pin, so no false edge after reset
            attn_q  <= 2'h3;
            ist     <= 8'h00;
            imask   <= 8'h00;
            rdata_o <= 8'h00;
            irq_o   <= 1'b0;
        end else begin
            link.port_select_n       <= !(state == M_SETUP || state == M_STROBE); // [R12]
            link.port_read_strobe_n  <= !(state == M_STROBE && is_rd); // [R1]
            link.port_write_strobe_n <= !(state == M_STROBE && !is_rd);
            link.register_select     <= sel;
            link.bus_from_master     <= wbyte;
            link.master_drive        <= busy && !is_rd;
            attn_q <= {attn_q[0], link.attention_out_n}; // [R12]
            if (wr_i && addr_i == spp_pkg::MA_IRQ_MK) imask <= wdata_i[7:0];
            ist <= (ist & ~((wr_i && addr_i == spp_pkg::MA_IRQ_ST) ? wdata_i[7:0] : 8'h00)) | ev;
            irq_o <= |(ist & imask);
            case (addr_i)
                spp_pkg::MA_RDATA:  rdata_o <= rd_i ? rbyte : 8'h00;
                spp_pkg::MA_STAT:   rdata_o <= rd_i ? {6'h00, !attn_q[0], busy} : 8'h00;
                spp_pkg::MA_IRQ_ST: rdata_o <= rd_i ? ist : 8'h00;
                spp_pkg::MA_IRQ_MK: rdata_o <= rd_i ? imask : 8'h00;
                default:            rdata_o <= 8'h00;
            endcase
        end
    end
endmodule : spp_master
`default_nettype wire

// *** rtl/spp_pkg.sv ***
// shared constants for the slave parallel port and its master
`default_nettype none
package spp_pkg;
    // ------------------------------------------------------------
    // register select codes on the port
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_DATA0  = 2'h0;
    localparam logic [1:0] SEL_DATA1  = 2'h1;
    localparam logic [1:0] SEL_DATA2  = 2'h2;
    localparam logic [1:0] SEL_STATUS = 2'h3;
    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int ST_MWR0 = 7;
    localparam int ST_IN_LO = 4;
    localparam int ST_PWR0 = 3;
    localparam int ST_OUT_LO = 0;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CT_MODE_LO = 2;
    localparam int CT_PRIO_LO = 0;
    localparam logic [1:0] MODE_SLAVE = 2'h2;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // ------------------------------------------------------------
    // processor-side register addresses (slave end)
    // ------------------------------------------------------------
    localparam logic [3:0] PA_DATA0  = 4'h0;
    localparam logic [3:0] PA_DATA1  = 4'h1;
    localparam logic [3:0] PA_DATA2  = 4'h2;
    localparam logic [3:0] PA_STATUS = 4'h3;
    localparam logic [3:0] PA_CTRL   = 4'h4;
    localparam logic [3:0] PA_IRQ_ST = 4'h5;
    localparam logic [3:0] PA_IRQ_MK = 4'h6;
    // ------------------------------------------------------------
    // master-side command registers (master end)
    // ------------------------------------------------------------
    localparam logic [3:0] MA_CMD    = 4'h0;
    localparam logic [3:0] MA_RDATA  = 4'h1;
    localparam logic [3:0] MA_STAT   = 4'h2;
    localparam logic [3:0] MA_IRQ_ST = 4'h3;
    localparam logic [3:0] MA_IRQ_MK = 4'h4;
    // cmd: bit9 go-read, bit8 go-write, bits 7:0 data, bits 11:10 select
    localparam int CMD_RD  = 9;
    localparam int CMD_WR  = 8;
    localparam int CMD_SEL = 10;
    // ------------------------------------------------------------
    // strobe timing at 50 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int STROBE_LOW_NS = 40;
    localparam int STROBE_GAP_NS = 40;
    localparam int SETUP_NS      = 10;
    localparam int STROBE_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC    = (STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // the slave samples strobes through two flops plus an edge flop,
    // so the master holds each strobe long enough for that path
    localparam int HOLD_CYC = STROBE_CYC + 4;
endpackage : spp_pkg
`default_nettype wire

// *** rtl/spp_slave.sv ***
// slave end: data registers, status, attention and processor interrupt
//
// Function
// R1 - master moves bytes using strobes and selects
// R2 - master write of data zero raises interrupt
// R3 - master writes data zero last
// R4 - processor write of data zero asserts attention
// R5 - master reads outbound bytes after attention
// R6 - any register access clears pending requests; PA_CTRL, PA_IRQ_ST and PA_IRQ_MK accesses do not clear them
// R7 - status write is dummy access, data kept
// R8 - nonzero priority enables interrupts immediately
// R9 - polled exchange through data zero and status
// R10 - pollers read status twice until equal
// R11 - no read overlaps write of same register
// R12 - master gives separate select and attention input
// R13 - synchronise strobes, act once per access
// R14 - select codes choose data zero-two or status
// R15 - full on source write, empty on destination read
// R16 - status bit layout of flags and full bits
// R17 - control mode ten enables the port pins
`timescale 1ns/1ps
`default_nettype none
module spp_slave (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // processor register port
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // processor interrupts
    output logic            port_irq_o,
    output logic      [1:0] port_irq_prio_o,
    output logic            irq_o,
    // link to the master
    spp_if.slave            link
);
    // ------------------------------------------------------------
    // synchronisers and strobe edges
    // ------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [1:0] sel_q;
    logic [7:0] bus_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            sync3 <= 3'h7;
        end else begin
            sync1 <= {link.port_select_n, link.port_read_strobe_n, link.port_write_strobe_n}; // [R13]
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    // select and data are stable around strobes, sampled directly
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_q <= 2'h0;
            bus_q <= 8'h00;
        end else begin
            sel_q <= link.register_select;
            bus_q <= link.port_byte_bus;
        end
    end
    logic [7:0] ctrl;
    wire enabled  = ctrl[spp_pkg::CT_MODE_LO +: 2] == spp_pkg::MODE_SLAVE; // [R17]
    wire cs_act   = !sync2[2] && enabled;
    wire m_rd_low = cs_act && !sync2[1];
    // one event per strobe: rising edge of write, falling edge of read
    wire m_wr = enabled && !sync3[2] && !sync3[0] && sync2[0]; // [R13] [R1]
    wire m_rd = m_rd_low && sync3[1]; // [R13]
    // ------------------------------------------------------------
    // processor decode
    // ------------------------------------------------------------
    wire p_wr_d = wr_i && addr_i < spp_pkg::PA_STATUS;
    wire p_rd_d = rd_i && addr_i < spp_pkg::PA_STATUS;
    wire p_port = (wr_i || rd_i) && addr_i <= spp_pkg::PA_STATUS; // [R6]
    wire m_any  = m_wr || m_rd;
    // ------------------------------------------------------------
    // data registers and flags
    // ------------------------------------------------------------
    logic [7:0] in_reg  [3];
    logic [7:0] out_reg [3];
    logic [2:0] in_full;
    logic [2:0] out_full;
    logic       mwr0;
    logic       pwr0;
    logic       attn_n;
    logic [7:0] ist;
    logic [7:0] imask;
    wire m_wr_data = m_wr && sel_q != spp_pkg::SEL_STATUS; // [R7]
    wire m_wr0     = m_wr && sel_q == spp_pkg::SEL_DATA0;  // [R3]
    wire p_wr0     = wr_i && addr_i == spp_pkg::PA_DATA0;
    wire [7:0] status = {mwr0, in_full, pwr0, out_full}; // [R16]
    wire [1:0] pidx = addr_i[1:0];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                in_reg[i]  <= 8'h00;
                out_reg[i] <= 8'h00;
            end
            in_full  <= 3'h0;
            out_full <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                // set beats clear when both land together
                if (m_wr_data && sel_q == 2'(i)) begin
                    in_reg[i]  <= bus_q;
                    in_full[i] <= 1'b1; // [R15]
                end else if (p_rd_d && pidx == 2'(i)) begin
                    in_full[i] <= 1'b0; // [R15]
                end
                if (p_wr_d && pidx == 2'(i)) begin
                    out_reg[i]  <= wdata_i;
                    out_full[i] <= 1'b1; // [R15]
                end else if (m_rd && sel_q == 2'(i)) begin
                    out_full[i] <= 1'b0; // [R15]
                end
            end
        end
    end
    // ------------------------------------------------------------
    // pending requests: interrupt to processor, attention to master
    // ------------------------------------------------------------
    wire prio_on = ctrl[spp_pkg::CT_PRIO_LO +: 2] != 2'h0; // [R8]
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mwr0   <= 1'b0;
            pwr0   <= 1'b0;
            attn_n <= 1'b1;
        end else begin
            if (m_wr0) begin
                mwr0 <= 1'b1; // [R2]
            end else if (p_port || m_any) begin
                mwr0 <= 1'b0; // [R6] [R7]
            end
            if (p_wr0) begin
                pwr0   <= 1'b1;
                attn_n <= 1'b0; // [R4] [R9]
            end else if (p_port || m_any) begin
                pwr0   <= 1'b0;
                attn_n <= 1'b1; // [R6]
            end
        end
    end
    // ------------------------------------------------------------
    // control, sticky events, processor read data
    // ------------------------------------------------------------
    wire [7:0] ev = {5'h00, m_rd, p_wr0, m_wr0 && prio_on};
    logic [7:0] next_rdata;
    always_comb begin
        case (addr_i)
            spp_pkg::PA_DATA0, spp_pkg::PA_DATA1, spp_pkg::PA_DATA2:
                next_rdata = (pidx == 2'h3) ? 8'h00 : in_reg[pidx];
            spp_pkg::PA_STATUS: next_rdata = status;
            spp_pkg::PA_CTRL:   next_rdata = ctrl;
            spp_pkg::PA_IRQ_ST: next_rdata = ist;
            spp_pkg::PA_IRQ_MK: next_rdata = imask;
            default:            next_rdata = 8'h00;
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl    <= spp_pkg::CTRL_RST;
            ist     <= 8'h00;
            imask   <= 8'h00;
            rdata_o <= 8'h00;
            irq_o   <= 1'b0;
        end else begin
            if (wr_i && addr_i == spp_pkg::PA_CTRL) ctrl <= wdata_i; // [R8] [R17]
            if (wr_i && addr_i == spp_pkg::PA_IRQ_MK) imask <= wdata_i;
            ist <= (ist & ~((wr_i && addr_i == spp_pkg::PA_IRQ_ST) ? wdata_i : 8'h00)) | ev;
            rdata_o <= rd_i ? next_rdata : 8'h00;
            irq_o   <= |(ist & imask);
        end
    end
    assign port_irq_prio_o = ctrl[spp_pkg::CT_PRIO_LO +: 2];
    // pins come from flops; costs one cycle of latency
    logic attn_pin;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_irq_o <= 1'b0;
            attn_pin   <= 1'b1;
        end else begin
            port_irq_o <= mwr0 && prio_on; // [R2] [R8]
            attn_pin   <= attn_n || !enabled; // [R4] [R17]
        end
    end
    // ------------------------------------------------------------
    // link outputs; drive while synchronised select and read strobe are low, one cycle late
    // ------------------------------------------------------------
    logic [7:0] drv;
    logic       drv_en;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv    <= 8'h00;
            drv_en <= 1'b0;
        end else begin
            drv_en <= m_rd_low; // [R14]
            drv    <= (sel_q == spp_pkg::SEL_STATUS) ? status : out_reg[sel_q]; // [R14] [R11]
        end
    end
    assign link.bus_from_slave  = drv;
    assign link.slave_drive     = drv_en;
    assign link.attention_out_n = attn_pin;
endmodule : spp_slave
`default_nettype wire
